// File: hdl/sat_accumulator.sv
// saturating signed integration accumulator
`timescale 1ns/1ns
module sat_accumulator (
  input  wire logic        clk,       // bus clock
  input  wire logic        srst,      // sync reset
  input  wire logic        clear,     // hold at zero
  input  wire logic        sample,    // converter sample strobe
  input  wire logic        up,        // sample direction
  output logic [15:0]      acc,       // accumulated value
  output logic             saturated  // pulse on saturation
);
  wire at_max = (acc == stall_pkg::acc_max);
  wire at_min = (acc == stall_pkg::acc_min);

  // freezes at the rail instead of wrapping
  always_ff @(posedge clk) begin
    if (srst || clear) begin
      acc       <= stall_pkg::count_zero;
      saturated <= 1'b0;
    end else if (sample) begin
      saturated <= up ? at_max : at_min;
      if (up && !at_max)
        acc <= acc + 16'h0001;
      else if (!up && !at_min)
        acc <= acc - 16'h0001;
    end else begin
      saturated <= 1'b0;
    end
  end
endmodule : sat_accumulator

// File: hdl/stall_detector.sv
// stall detector control registers, down-counter and detector controls
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
// Overview of operation
// [R1] underflow flag with enable raises counter irq
// [R2] no reload: count down, stop at zero
// [R3] reload mode: reload from load register
// [R4] software disables counter before mode change
// [R5] readback select picks load or live count
// [R6] counter tick is clock over 64/512
// [R7] divider change applies at next load
// [R8] force load copies load, reads zero
// [R9] disabled counter held at all ones
// [R10] overflow flag with enable raises irq
// [R11] return home takes coil control
// [R12] converter power bit, recovery before valid
// [R13] wait shutdown stops prescaler and converter
// [R14] factory test bit reads zero
// [R15] sample clock is clock over 8*2^n
// [R16] sample rate change waits for integrate clear
// [R17] software keeps sample rate 500k-2M
// [R18] underflow flag set at zero, w1c
// [R19] overflow flag on saturation, w1c
// [R20] integrate clear holds accumulator, converter reset
// [R21] decrement by one per tick
module stall_detector (
  input  wire logic        clk,            // bus clock, 100 MHz
  input  wire logic        srst,           // sync reset, active high
  input  wire logic [3:0]  addr,           // register address
  input  wire logic [7:0]  wdata,          // write data
  input  wire logic        wr,             // write strobe
  input  wire logic        rd,             // read strobe
  output logic [7:0]       rdata,          // read data, cycle after rd
  input  wire logic        wait_mode,      // chip in wait mode
  input  wire logic        conv_bit,       // converter output bit
  output logic             counter_irq,    // underflow request
  output logic             overflow_irq,   // saturation request
  output logic             coil_control,   // coils owned by block
  output logic             coil_low_recirc,// recirculate via motor_low_supply
  output logic [1:0]       coil_step,      // selected full step
  output logic             converter_power,// converter powered
  output logic             converter_reset,// converter held in reset
  output logic             converter_ready // recovery time elapsed
);
  logic [7:0]  down_counter_control;
  logic [7:0]  stall_detector_control;
  logic [1:0]  full_step;
  logic [15:0] load_value;
  logic [15:0] count;
  logic        underflow_flag;
  logic        overflow_flag;
  logic        divider_active;   // divider applied at last load
  logic [1:0]  rate_active;      // sample rate in use
  logic [15:0] recovery_count;
  logic [15:0] acc;
  logic        saturated;
  logic        count_tick;
  logic        sample_tick;

  // decode
  wire wr_dcc   = wr && (addr == stall_pkg::offset_down_counter_control);
  wire wr_sdc   = wr && (addr == stall_pkg::offset_stall_detector_control);
  wire wr_flag  = wr && (addr == stall_pkg::offset_flags);
  wire wr_hi    = wr && (addr == stall_pkg::offset_count_high);
  wire wr_lo    = wr && (addr == stall_pkg::offset_count_low);
  wire wr_io    = wr && (addr == stall_pkg::offset_detector_io);

  // control fields
  wire irq_under_en = down_counter_control[stall_pkg::bit_underflow_irq_enable];
  wire reload_mode  = down_counter_control[stall_pkg::bit_reload_mode_enable];
  wire read_load    = down_counter_control[stall_pkg::bit_readback_load_select];
  wire divider_sel  = down_counter_control[stall_pkg::bit_divider_select];
  wire counter_en   = down_counter_control[stall_pkg::bit_down_counter_enable];
  wire irq_ovf_en   = down_counter_control[stall_pkg::bit_overflow_irq_enable];
  wire home_en      = stall_detector_control[stall_pkg::bit_return_home_enable];
  wire power_bit    = stall_detector_control[stall_pkg::bit_converter_power_on];
  wire wait_off     = stall_detector_control[stall_pkg::bit_wait_shutdown];
  wire integrating  = stall_detector_control[stall_pkg::bit_integrate_select];
  wire [1:0] rate_field = stall_detector_control[1:0];

  // wait shutdown stops and clears the prescalers and powers down the converter
  wire shut_down    = wait_mode && wait_off;                              // R13
  wire power_now    = power_bit && !shut_down;                            // R12

  // force load: a write of one, never stored
  wire force_load   = wr_dcc && wdata[stall_pkg::bit_force_count_load];  // R8
  wire write_count  = wr_lo;
  wire [15:0] written = {load_value[15:8], wdata};
  wire at_zero      = (count == stall_pkg::count_zero);
  wire dec_tick     = counter_en && count_tick && !at_zero;               // R21
  wire reaching_0   = dec_tick && (count == 16'h0001);                    // R18
  wire reload_now   = reload_mode && counter_en && count_tick && at_zero; // R3
  wire any_load     = force_load || reload_now || (write_count && !reload_mode);

  // counter tick prescaler: 2^6 or 2^9 from the divider in force
  tick_divider #(.width(stall_pkg::div_fast_log2)) count_div (
    .clk     (clk),
    .srst    (srst),
    .run     (counter_en && !shut_down),
    .restart (any_load),
    .log2div (divider_active ? 4'(stall_pkg::div_fast_log2)
                             : 4'(stall_pkg::div_slow_log2)),            // R6
    .tick    (count_tick)
  );

  // accumulator sample prescaler, 8 times 2^rate
  tick_divider #(.width(stall_pkg::sample_base_log2 + 3)) sample_div (
    .clk     (clk),
    .srst    (srst),
    .run     (integrating && power_now),
    .restart (!integrating),
    .log2div (4'(stall_pkg::sample_base_log2) + {2'h0, rate_active}),    // R15
    .tick    (sample_tick)
  );

  sat_accumulator accumulator (
    .clk       (clk),
    .srst      (srst),
    .clear     (!integrating),                                           // R20
    .sample    (sample_tick),
    .up        (conv_bit),
    .acc       (acc),
    .saturated (saturated)
  );

  // control registers; the strobe bit is masked out so it reads zero
  always_ff @(posedge clk) begin
    if (srst) begin
      down_counter_control   <= stall_pkg::reset_control;
      stall_detector_control <= stall_pkg::reset_control;
      full_step              <= 2'h0;
    end else begin
      if (wr_dcc)
        down_counter_control <= wdata & stall_pkg::mask_down_counter_control; // R8
      if (wr_sdc)
        stall_detector_control <= wdata & stall_pkg::mask_stall_detector_control; // R14
      if (wr_io)
        full_step <= wdata[1:0];
    end
  end

  // load register, written high byte first then low byte
  always_ff @(posedge clk) begin
    if (srst)
      load_value <= stall_pkg::count_zero;
    else if (wr_hi)
      load_value <= {wdata, load_value[7:0]};
    else if (wr_lo)
      load_value <= written;
  end

  // down-counter; disable preset avoids an early flag on enable
  always_ff @(posedge clk) begin
    if (srst || !counter_en)
      count <= stall_pkg::count_preset;                                  // R9
    else if (force_load)
      count <= load_value;                                               // R8
    else if (write_count && !reload_mode)
      count <= written;
    else if (reload_now)
      count <= load_value;                                               // R3
    else if (dec_tick)
      count <= count - 16'h0001;                                         // R2 R21
  end

  // divider select latched only when a load happens
  always_ff @(posedge clk) begin
    if (srst)
      divider_active <= 1'b0;
    else if (any_load)
      divider_active <= divider_sel;                                     // R7
  end

  // sample rate follows the field only while not integrating
  always_ff @(posedge clk) begin
    if (srst)
      rate_active <= 2'h0;
    else if (!integrating)
      rate_active <= rate_field;                                         // R16
  end

  // sticky flags, set wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (srst) begin
      underflow_flag <= 1'b0;
      overflow_flag  <= 1'b0;
    end else begin
      if (reaching_0)
        underflow_flag <= 1'b1;                                          // R18
      else if (wr_flag && wdata[stall_pkg::bit_underflow_flag])
        underflow_flag <= 1'b0;
      if (saturated)
        overflow_flag <= 1'b1;                                           // R19
      else if (wr_flag && wdata[stall_pkg::bit_overflow_flag])
        overflow_flag <= 1'b0;
    end
  end

  // converter recovery counter restarts on every power-up
  always_ff @(posedge clk) begin
    if (srst || !power_now)
      recovery_count <= 16'h0000;
    else if (recovery_count != 16'(stall_pkg::recovery_cycles))
      recovery_count <= recovery_count + 16'h0001;                       // R12
  end

  // read mux
  wire [15:0] count_view = read_load ? load_value : count;               // R5
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (addr == stall_pkg::offset_down_counter_control)
      next_rdata = down_counter_control;
    else if (addr == stall_pkg::offset_stall_detector_control)
      next_rdata = stall_detector_control;
    else if (addr == stall_pkg::offset_flags)
      next_rdata = {underflow_flag, 6'h00, overflow_flag};
    else if (addr == stall_pkg::offset_count_high)
      next_rdata = count_view[15:8];
    else if (addr == stall_pkg::offset_count_low)
      next_rdata = count_view[7:0];
    else if (addr == stall_pkg::offset_detector_io)
      next_rdata = {6'h00, full_step};
  end

  // registered outputs; irq follows flag one cycle later
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata           <= 8'h00;
      counter_irq     <= 1'b0;
      overflow_irq    <= 1'b0;
      coil_control    <= 1'b0;
      coil_low_recirc <= 1'b0;
      coil_step       <= 2'h0;
      converter_power <= 1'b0;
      converter_reset <= 1'b1;
      converter_ready <= 1'b0;
    end else begin
      rdata           <= rd ? next_rdata : 8'h00;
      counter_irq     <= underflow_flag && irq_under_en;                 // R1
      overflow_irq    <= overflow_flag && irq_ovf_en;                    // R10
      coil_control    <= home_en;                                        // R11
      coil_low_recirc <= home_en && shut_down;                           // R13
      coil_step       <= full_step;                                      // R11
      converter_power <= power_now;                                      // R12
      converter_reset <= !integrating;                                   // R20
      converter_ready <= power_now &&
                         (recovery_count == 16'(stall_pkg::recovery_cycles));
    end
  end
endmodule : stall_detector

// File: hdl/stall_pkg.sv
// constants shared by the stall detector control logic
package stall_pkg;
  // register offsets (byte addresses on the strobed register port)
  localparam logic [3:0] offset_down_counter_control   = 4'h1;
  localparam logic [3:0] offset_stall_detector_control = 4'h2;
  localparam logic [3:0] offset_flags                  = 4'h3;
  localparam logic [3:0] offset_count_high             = 4'h4;
  localparam logic [3:0] offset_count_low              = 4'h5;
  localparam logic [3:0] offset_detector_io            = 4'h6;
  // down_counter_control fields
  localparam int bit_underflow_irq_enable  = 7;
  localparam int bit_reload_mode_enable    = 6;
  localparam int bit_readback_load_select  = 5;
  localparam int bit_divider_select        = 4;
  localparam int bit_force_count_load      = 3;
  localparam int bit_down_counter_enable   = 2;
  localparam int bit_overflow_irq_enable   = 0;
  // stall_detector_control fields
  localparam int bit_return_home_enable    = 7;
  localparam int bit_converter_power_on    = 6;
  localparam int bit_wait_shutdown         = 5;
  localparam int bit_factory_test_bit      = 4;
  localparam int bit_integrate_select      = 2;
  // flag register fields
  localparam int bit_underflow_flag        = 7;
  localparam int bit_overflow_flag         = 0;
  // writable masks, reset values and accumulator rails
  localparam logic [7:0] mask_down_counter_control   = 8'hf5;
  localparam logic [7:0] mask_stall_detector_control = 8'he7;
  localparam logic [7:0] reset_control               = 8'h00;
  localparam logic [15:0] count_preset               = 16'hffff;
  localparam logic [15:0] count_zero                 = 16'h0000;
  localparam logic [15:0] acc_max                    = 16'h7fff;
  localparam logic [15:0] acc_min                    = 16'h8000;
  // prescaler ratios
  localparam int div_slow_log2   = 6;
  localparam int div_fast_log2   = 9;
  localparam int sample_base_log2 = 3;
  // converter recovery time after power-up
  localparam int clk_mhz          = 100;
  localparam int recovery_us      = 10;
  localparam int recovery_cycles  = recovery_us * clk_mhz;
endpackage : stall_pkg

// File: hdl/tick_divider.sv
// free-running power-of-two tick divider
`timescale 1ns/1ns
module tick_divider #(
  parameter int width = 9
) (
  input  wire logic             clk,     // bus clock
  input  wire logic             srst,    // sync reset
  input  wire logic             run,     // count enable
  input  wire logic             restart, // clear the divider
  input  wire logic [3:0]       log2div, // ratio as power of two
  output logic                  tick     // one-cycle tick
);
  logic [width-1:0] count;
  logic [width-1:0] limit;

  // terminal count is ratio minus one
  assign limit = width'((32'd1 << log2div) - 32'd1);

  always_ff @(posedge clk) begin
    if (srst || restart || !run) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count >= limit) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + width'(1);
      tick  <= 1'b0;
    end
  end
endmodule : tick_divider

// File: tb/conv_model.sv
// behavioural sigma-delta front end facing the detector
`timescale 1ns/1ns
module conv_model (
  input  wire logic clk,      // clock
  input  wire logic powered,  // converter powered
  input  wire logic in_reset, // converter held in reset
  output logic      conv_bit  // sample bit
);
  logic [2:0] phase = 3'h0; // bias pattern, mostly upward
  // unpowered output toggles so a stale level never passes for data
  always_ff @(posedge clk) begin
    phase    <= phase + 3'h1;
    conv_bit <= (powered && !in_reset) ? (phase != 3'h0) : !conv_bit;
  end
endmodule : conv_model

// File: tb/stall_detector_asserts.sv
// port-level checker for the stall detector control block
`timescale 1ns/1ns
module stall_detector_asserts (
  input wire logic       clk,             // clock
  input wire logic       srst,            // reset
  input wire logic [3:0] addr,            // address
  input wire logic [7:0] wdata,           // write data
  input wire logic       wr,              // write strobe
  input wire logic       rd,              // read strobe
  input wire logic [7:0] rdata,           // read data
  input wire logic       wait_mode,       // wait mode
  input wire logic       counter_irq,     // underflow irq
  input wire logic       overflow_irq,    // overflow irq
  input wire logic       coil_control,    // coils owned
  input wire logic       coil_low_recirc, // low-side recirc
  input wire logic       converter_power, // converter on
  input wire logic       converter_reset, // converter reset
  input wire logic       converter_ready  // recovery done
);
  logic [7:0]  mdc;     // shadow of down_counter_control
  logic [7:0]  sdc;     // shadow of stall_detector_control
  logic [10:0] pwr_cnt; // cycles powered, saturating
  wire         p_exp  = sdc[6] & ~(sdc[5] & wait_mode);
  wire         rc_exp = sdc[7] & sdc[5] & wait_mode;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // shadows let each output be tied to the write that caused it
  always_ff @(posedge clk) begin
    if (srst) begin
      mdc     <= 8'h00;
      sdc     <= 8'h00;
      pwr_cnt <= 11'h000;
    end else begin
      if (wr && addr == 4'h1) mdc <= wdata & 8'hf5;
      if (wr && addr == 4'h2) sdc <= wdata & 8'he7;
      if (!converter_power) pwr_cnt <= 11'h000;
      else if (pwr_cnt != 11'h7ff) pwr_cnt <= pwr_cnt + 11'h001;
    end
  end
  a_uirq_masked: assert property (counter_irq |-> $past(mdc[7]))
    else $error("counter irq while masked");
  a_oirq_masked: assert property (overflow_irq |-> $past(mdc[0]))
    else $error("overflow irq while masked");
  a_ctl_readback: assert property ($past(rd) && $past(addr) == 4'h1 |-> rdata == $past(mdc))
    else $error("counter control readback wrong");
  a_det_readback: assert property ($past(rd) && $past(addr) == 4'h2 |-> rdata == $past(sdc))
    else $error("detector control readback wrong");
  a_coil_owner: assert property (coil_control == sdc[7] || coil_control == $past(sdc[7]))
    else $error("coil ownership wrong");
  a_conv_power: assert property (converter_power == p_exp || converter_power == $past(p_exp))
    else $error("converter power wrong");
  a_low_recirc: assert property (coil_low_recirc == rc_exp || coil_low_recirc == $past(rc_exp))
    else $error("low-side recirculation wrong");
  a_conv_reset: assert property (converter_reset == !sdc[2] || converter_reset == !$past(sdc[2]))
    else $error("converter reset wrong");
  a_ready_early: assert property ($rose(converter_ready) |-> pwr_cnt >= 11'd998)
    else $error("converter ready too early");
  a_ready_late: assert property (pwr_cnt == 11'd1010 |-> converter_ready)
    else $error("converter ready too late");
  c_underflow: cover property ($rose(counter_irq));
  c_ready: cover property ($rose(converter_ready));
  c_recirc: cover property ($rose(coil_low_recirc));
endmodule : stall_detector_asserts

bind stall_detector stall_detector_asserts chk_u (
  .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .wait_mode(wait_mode), .counter_irq(counter_irq), .overflow_irq(overflow_irq),
  .coil_control(coil_control), .coil_low_recirc(coil_low_recirc),
  .converter_power(converter_power), .converter_reset(converter_reset),
  .converter_ready(converter_ready));

// File: tb/stall_detector_tb.sv
// self-checking bench for the stall detector control registers
`timescale 1ns/1ns
module stall_detector_tb;
  logic        clk, srst, wr, rd, wait_mode, conv_bit;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, b;
  logic [15:0] c, d;
  logic [1:0]  coil_step;
  logic        counter_irq, overflow_irq, coil_control, coil_low_recirc;
  logic        converter_power, converter_reset, converter_ready;
  int          fails = 0, checks_done = 0, cyc = 0;

  stall_detector dut_u (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .wait_mode(wait_mode), .conv_bit(conv_bit),
    .counter_irq(counter_irq), .overflow_irq(overflow_irq), .coil_control(coil_control),
    .coil_low_recirc(coil_low_recirc), .coil_step(coil_step),
    .converter_power(converter_power), .converter_reset(converter_reset),
    .converter_ready(converter_ready));
  conv_model far_u (.clk(clk), .powered(converter_power), .in_reset(converter_reset),
    .conv_bit(conv_bit));

  task automatic close_out;
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("Error %0t: value %h expected %h", $time, g, e);
    end
  endtask : chk16
  task automatic chk1(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("Error %0t: bit %b expected %b", $time, g, e);
    end
  endtask : chk1
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    rd_reg(a, b);
    chk16({8'h00, b}, {8'h00, e});
  endtask : rchk
  task automatic rd_cnt(output logic [15:0] v);
    logic [7:0] h;
    logic [7:0] l;
    rd_reg(4'h4, h);
    rd_reg(4'h5, l);
    v = {h, l};
  endtask : rd_cnt
  task automatic load(input logic [7:0] lo);
    wr_reg(4'h4, 8'h00);
    wr_reg(4'h5, lo);
  endtask : load

  // free-running clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end

  initial begin
    srst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 8'h00; wait_mode = 1'b0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    // masks, strobe bit and unmapped place
    wr_reg(4'h1, 8'hfb);
    rchk(4'h1, 8'hf1);
    chk1(overflow_irq, 1'b0);
    rchk(4'h0, 8'h00);
    wr_reg(4'h1, 8'h00);
    rd_cnt(c);
    chk16(c, 16'hffff);
    wr_reg(4'h2, 8'hff);
    rchk(4'h2, 8'he7);
    idle(2);
    chk1(coil_control, 1'b1);
    chk1(converter_reset, 1'b0);
    @(posedge clk) wait_mode <= 1'b1;
    idle(3);
    chk1(converter_power, 1'b0);
    chk1(coil_low_recirc, 1'b1);
    @(posedge clk) wait_mode <= 1'b0;
    idle(3);
    chk1(converter_ready, 1'b0);
    idle(1020);
    chk1(converter_ready, 1'b1);
    // no shutdown in wait, rate kept in the recommended band
    wr_reg(4'h2, 8'hc3);
    @(posedge clk) wait_mode <= 1'b1;
    idle(3);
    chk1(converter_power, 1'b1);
    chk1(coil_low_recirc, 1'b0);
    chk1(converter_reset, 1'b1);
    @(posedge clk) wait_mode <= 1'b0;
    wr_reg(4'h6, 8'h02);
    wr_reg(4'h2, 8'h00);
    idle(3);
    chk1(coil_control, 1'b0);
    chk16({14'h0000, coil_step}, 16'h0002);
    // one-shot count of three at the slow divider
    wr_reg(4'h1, 8'h84);
    load(8'h03);
    idle(100);
    rd_cnt(c);
    chk1(c == 16'h0001 || c == 16'h0002, 1'b1);
    idle(200);
    rd_cnt(c);
    chk16(c, 16'h0000);
    chk1(counter_irq, 1'b1);
    wr_reg(4'h1, 8'h04);
    wr_reg(4'h3, 8'h00);
    idle(300);
    rd_cnt(c);
    chk16(c, 16'h0000);
    chk1(counter_irq, 1'b0);
    rchk(4'h3, 8'h80);
    wr_reg(4'h3, 8'h80);
    rchk(4'h3, 8'h00);
    // divider switch waits for the next load
    load(8'h08);
    wr_reg(4'h1, 8'h14);
    idle(650);
    rd_cnt(c);
    chk16(c, 16'h0000);
    load(8'h03);
    idle(900);
    rd_cnt(c);
    chk1(c != 16'h0000, 1'b1);
    idle(700);
    rd_cnt(c);
    chk16(c, 16'h0000);
    // reload mode, counter stopped first
    wr_reg(4'h1, 8'h00);
    wr_reg(4'h1, 8'h60);
    load(8'h05);
    rd_cnt(c);
    chk16(c, 16'h0005);
    // enable first: a disabled counter keeps its preset over a force load
    wr_reg(4'h1, 8'h44);
    wr_reg(4'h1, 8'h4c);
    wr_reg(4'h3, 8'h80);
    idle(450);
    rchk(4'h3, 8'h80);
    rd_cnt(c);
    idle(70);
    rd_cnt(d);
    chk1((c | d) != 16'h0000 && c <= 16'h0005 && d <= 16'h0005, 1'b1);
    wr_reg(4'h1, 8'h00);
    rd_cnt(c);
    chk16(c, 16'hffff);
    close_out();
  end
endmodule : stall_detector_tb
